// ===== design/sspt_map.vh
/*
 * constants for the periodic split pipeline tracker.
 * assumes: included by the tracker file; definitions only.
 */
`ifndef SSPT_MAP_VH
`define SSPT_MAP_VH
// ====================
// pipeline geometry
`define SSPT_UF_PER_FRAME 8
`define SSPT_SS_UFRAMES   4
`define SSPT_CS_UFRAMES   2
`define SSPT_TX_PER_UF    16
`define SSPT_SS_STALE_AGE 3'h4
`define SSPT_CS_FREE_AGE  3'h2
// ====================
// byte sizes: start-split use stays below SSPT_SS_DATA_BYTES, complete-split use below twice SSPT_CS_DATA_BYTES
`define SSPT_SS_DATA_BYTES 16'h02F0
`define SSPT_CS_DATA_BYTES 16'h00BC
`define SSPT_STATUS_BYTES  4
// ====================
// start-split entry states
`define SSPT_SS_FREE 2'h0
`define SSPT_SS_STOR 2'h1
`define SSPT_SS_PEND 2'h2
`define SSPT_SS_EXEC 2'h3
// ====================
// search machine states
`define SSPT_SR_IDLE 1'h0
`define SSPT_SR_SCAN 1'h1
`endif

// ===== design/sspt_tracker.v
/*
 * periodic split pipeline tracker of a hub split_translator, plus its
 * result FIFO. assumes one clock, a one-cycle microframe tick from the
 * hub timer, and a downstream handler that starts, finishes or drops
 * one transaction at a time.
 */
`timescale 1ns/1ns
`include "sspt_map.vh"

// ====================
// result FIFO
module sspt_fifo #(
    parameter W     = 24,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire         ref_clk,   // clock
    input  wire         arst_n,    // async reset
    input  wire         in_valid,  // write request
    output wire         in_ready,  // not full
    input  wire [W-1:0] in_data,   // write word
    output wire         out_valid, // not empty
    input  wire         out_ready, // read accept
    output wire [W-1:0] out_data   // head word
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW:0]  wp;
    reg [AW:0]  rp;
    wire        full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = (wp != rp);
    assign out_data  = mem[rp[AW-1:0]];
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp <= {(AW+1){1'b0}};
            rp <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                mem[wp[AW-1:0]] <= in_data;
                wp <= wp + 1'b1;
            end
            if (out_valid && out_ready)
                rp <= rp + 1'b1;
        end
    end
endmodule

// ====================
// tracker top
module sspt_tracker #(
    parameter ID_W   = 11,
    parameter LEN_W  = 10,
    parameter CODE_W = 3,
    parameter SS_AW  = 6,
    parameter CS_AW  = 5
) (
    input  wire              ref_clk,      // 25 MHz clock
    input  wire              arst_n,       // async reset
    input  wire              uf_tick,      // microframe start pulse
    output reg  [2:0]        uf_pos,       // microframe in frame
    input  wire              ss_valid,     // start-split stored
    output wire              ss_ready,     // space for it
    input  wire [ID_W-1:0]   ss_ep,        // endpoint id
    input  wire [LEN_W-1:0]  ss_len,       // data bytes
    input  wire              ss_intr,      // interrupt type
    output wire              dn_valid,     // pending work offered
    output wire [ID_W-1:0]   dn_ep,        // its endpoint
    output wire [LEN_W-1:0]  dn_len,       // its length
    input  wire              dn_start,     // handler takes it
    output reg               dn_abort,     // drop running transaction
    output reg               dn_no_retry,  // running one is interrupt
    input  wire              rs_valid,     // downstream result
    output wire              rs_ready,     // result accepted
    input  wire [LEN_W-1:0]  rs_len,       // result data bytes
    input  wire [CODE_W-1:0] rs_code,      // result status
    input  wire              cs_valid,     // complete-split arrives
    output wire              cs_ready,     // search idle
    input  wire [ID_W-1:0]   cs_ep,        // its endpoint
    output reg               cs_rsp_valid, // answer pulse
    output reg               cs_rsp_nyet,  // no match
    output reg  [CODE_W-1:0] cs_rsp_code,  // matched status
    output reg  [LEN_W-1:0]  cs_rsp_len    // matched length
);
    localparam SS_N = `SSPT_SS_UFRAMES * `SSPT_TX_PER_UF;
    localparam CS_N = `SSPT_CS_UFRAMES * `SSPT_TX_PER_UF;
    localparam FW   = ID_W + LEN_W + CODE_W;
    localparam [15:0] SS_LIM = `SSPT_SS_DATA_BYTES;
    localparam [15:0] CS_LIM = `SSPT_CS_DATA_BYTES + `SSPT_CS_DATA_BYTES;
    // the non-periodic buffers live outside this tracker

    function [2:0] age;
        input [2:0] now;
        input [2:0] tag;
        age = now - tag;
    endfunction

    // receive microframe and endpoint per entry
    reg [1:0]       ss_st  [0:SS_N-1];
    reg [2:0]       ss_tag [0:SS_N-1];
    reg [ID_W-1:0]  ss_id  [0:SS_N-1];
    reg [LEN_W-1:0] ss_ln  [0:SS_N-1];
    reg             ss_int [0:SS_N-1];
    reg [SS_AW-1:0] ss_wr;
    reg [SS_AW-1:0] ss_rd;
    reg [SS_AW-1:0] ex_idx;
    reg             ex_busy;
    reg             cs_v   [0:CS_N-1];
    reg [2:0]       cs_tag [0:CS_N-1];
    reg [ID_W-1:0]  cs_id  [0:CS_N-1];
    reg [LEN_W-1:0] cs_ln  [0:CS_N-1];
    reg [CODE_W-1:0] cs_cd [0:CS_N-1];
    reg [CS_AW-1:0] cs_wr;
    reg [CS_AW-1:0] cs_hd;
    reg             sr_st;
    reg [CS_AW-1:0] sr_pos;
    reg [CS_AW:0]   sr_cnt;
    reg [ID_W-1:0]  sr_key;
    reg [15:0]      ss_bytes;
    reg [15:0]      cs_bytes;
    integer         i;
    integer         j;
    integer         k;

    wire [2:0] uf_nx  = uf_pos + 3'h1;
    wire [2:0] tag_in = uf_tick ? uf_nx : uf_pos;
    wire       f_ov;
    wire       f_rd;
    wire [FW-1:0] f_dat;

    // ====================
    // byte accounting over live entries
    always @* begin
        ss_bytes = 16'h0000;
        cs_bytes = 16'h0000;
        for (i = 0; i < SS_N; i = i + 1)
            if (ss_st[i] != `SSPT_SS_FREE)
                ss_bytes = ss_bytes + {{(16-LEN_W){1'b0}}, ss_ln[i]};
        for (i = 0; i < CS_N; i = i + 1)
            if (cs_v[i])
                cs_bytes = cs_bytes + {{(16-LEN_W){1'b0}}, cs_ln[i]};
    end

    // full ring or byte budget refuses new work
    assign ss_ready = (ss_st[ss_wr] == `SSPT_SS_FREE) &&
                      (ss_bytes + {{(16-LEN_W){1'b0}}, ss_len} < SS_LIM);
    // no dispatch on the tick edge, so ageing and start never collide
    assign dn_valid = (ss_st[ss_rd] == `SSPT_SS_PEND) && !ex_busy && !uf_tick;
    assign dn_ep    = ss_id[ss_rd];
    assign dn_len   = ss_ln[ss_rd];
    wire   f_irdy;
    // results of a dropped transaction are swallowed
    assign rs_ready = f_irdy || !ex_busy;
    wire   abort    = uf_tick && ex_busy &&
                      (age(uf_nx, ss_tag[ex_idx]) >= `SSPT_SS_STALE_AGE);
    // a result landing in the abort cycle is dropped, the stale entry wins
    wire   f_push   = rs_valid && ex_busy && !abort;
    wire   done     = f_push && f_irdy;

    sspt_fifo #(.W(FW), .DEPTH(16), .AW(4)) u_fifo (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (f_push),
        .in_ready  (f_irdy),
        .in_data   ({ss_id[ex_idx], rs_len, rs_code}),
        .out_valid (f_ov),
        .out_ready (f_rd),
        .out_data  (f_dat)
    );

    assign f_rd = f_ov && !cs_v[cs_wr] &&
                  (cs_bytes + {{(16-LEN_W){1'b0}}, f_dat[CODE_W +: LEN_W]} < CS_LIM);

    // ====================
    // start-split stage
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (j = 0; j < SS_N; j = j + 1) begin
                ss_st[j]  <= `SSPT_SS_FREE;
                ss_tag[j] <= 3'h0;
                ss_id[j]  <= {ID_W{1'b0}};
                ss_ln[j]  <= {LEN_W{1'b0}};
                ss_int[j] <= 1'b0;
            end
            ss_wr       <= {SS_AW{1'b0}};
            ss_rd       <= {SS_AW{1'b0}};
            ex_idx      <= {SS_AW{1'b0}};
            ex_busy     <= 1'b0;
            dn_abort    <= 1'b0;
            dn_no_retry <= 1'b0;
            uf_pos      <= 3'h0;
        end else begin
            dn_abort <= abort;
            if (uf_tick)
                uf_pos <= uf_nx;
            if (ss_valid && ss_ready) begin
                ss_st[ss_wr]  <= `SSPT_SS_STOR;
                ss_tag[ss_wr] <= tag_in;
                ss_id[ss_wr]  <= ss_ep;
                ss_ln[ss_wr]  <= ss_len;
                ss_int[ss_wr] <= ss_intr;
                ss_wr <= ss_wr + 1'b1;
            end
            if (dn_valid && dn_start) begin
                ss_st[ss_rd] <= `SSPT_SS_EXEC;
                ex_idx       <= ss_rd;
                ex_busy      <= 1'b1;
                dn_no_retry  <= ss_int[ss_rd];
                ss_rd        <= ss_rd + 1'b1;
            end else if (ss_rd != ss_wr && ss_st[ss_rd] == `SSPT_SS_FREE) begin
                ss_rd <= ss_rd + 1'b1;
            end
            if (done) begin
                ss_st[ex_idx] <= `SSPT_SS_FREE;
                ex_busy       <= 1'b0;
            end
            if (uf_tick) begin
                for (j = 0; j < SS_N; j = j + 1) begin
                    if ((ss_st[j] == `SSPT_SS_PEND || ss_st[j] == `SSPT_SS_EXEC) &&
                        age(uf_nx, ss_tag[j]) >= `SSPT_SS_STALE_AGE)
                        ss_st[j] <= `SSPT_SS_FREE;
                    else if (ss_st[j] == `SSPT_SS_STOR &&
                             age(uf_nx, ss_tag[j]) != 3'h0)
                        ss_st[j] <= `SSPT_SS_PEND;
                end
                if (abort)
                    ex_busy <= 1'b0;
            end
        end
    end

    // ====================
    // complete-split stage and search
    // a search is dropped at the tick; the host times out and retries
    assign cs_ready = (sr_st == `SSPT_SR_IDLE) && !uf_tick;
    wire hit = cs_v[sr_pos] && cs_id[sr_pos] == sr_key &&
               age(uf_pos, cs_tag[sr_pos]) == 3'h1;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (k = 0; k < CS_N; k = k + 1) begin
                cs_v[k]   <= 1'b0;
                cs_tag[k] <= 3'h0;
                cs_id[k]  <= {ID_W{1'b0}};
                cs_ln[k]  <= {LEN_W{1'b0}};
                cs_cd[k]  <= {CODE_W{1'b0}};
            end
            cs_wr        <= {CS_AW{1'b0}};
            cs_hd        <= {CS_AW{1'b0}};
            sr_st        <= `SSPT_SR_IDLE;
            sr_pos       <= {CS_AW{1'b0}};
            sr_cnt       <= {(CS_AW+1){1'b0}};
            sr_key       <= {ID_W{1'b0}};
            cs_rsp_valid <= 1'b0;
            cs_rsp_nyet  <= 1'b0;
            cs_rsp_code  <= {CODE_W{1'b0}};
            cs_rsp_len   <= {LEN_W{1'b0}};
        end else begin
            cs_rsp_valid <= 1'b0;
            if (f_rd) begin
                cs_v[cs_wr]   <= 1'b1;
                cs_tag[cs_wr] <= tag_in;
                cs_id[cs_wr]  <= f_dat[FW-1 -: ID_W];
                cs_ln[cs_wr]  <= f_dat[CODE_W +: LEN_W];
                cs_cd[cs_wr]  <= f_dat[CODE_W-1:0];
                cs_wr <= cs_wr + 1'b1;
            end
            if (cs_hd != cs_wr && !cs_v[cs_hd])
                cs_hd <= cs_hd + 1'b1;
            case (sr_st)
                `SSPT_SR_IDLE: begin
                    if (cs_valid && cs_ready) begin
                        sr_key <= cs_ep;
                        sr_pos <= cs_hd;
                        sr_cnt <= {(CS_AW+1){1'b0}};
                        sr_st  <= `SSPT_SR_SCAN;
                    end
                end
                `SSPT_SR_SCAN: begin
                    if (uf_tick) begin
                        sr_st <= `SSPT_SR_IDLE;
                    end else if (hit) begin
                        cs_rsp_valid <= 1'b1;
                        cs_rsp_nyet  <= 1'b0;
                        cs_rsp_code  <= cs_cd[sr_pos];
                        cs_rsp_len   <= cs_ln[sr_pos];
                        for (k = 0; k < CS_N; k = k + 1)
                            if (k[CS_AW-1:0] - cs_hd < sr_pos - cs_hd)
                                cs_v[k] <= 1'b0;
                        cs_hd <= sr_pos;
                        sr_st <= `SSPT_SR_IDLE;
                    end else if (sr_cnt == CS_N - 1) begin
                        cs_rsp_valid <= 1'b1;
                        cs_rsp_nyet  <= 1'b1;
                        sr_st <= `SSPT_SR_IDLE;
                    end else begin
                        sr_pos <= sr_pos + 1'b1;
                        sr_cnt <= sr_cnt + 1'b1;
                    end
                end
                default: sr_st <= `SSPT_SR_IDLE;
            endcase
            if (uf_tick)
                for (k = 0; k < CS_N; k = k + 1)
                    if (age(uf_nx, cs_tag[k]) >= `SSPT_CS_FREE_AGE &&
                        !(f_rd && k[CS_AW-1:0] == cs_wr))
                        cs_v[k] <= 1'b0;
        end
    end
endmodule

// ===== tb/sspt_tracker_sva.sv
/* port checker for the split pipeline tracker.
   assumes: bound into sspt_tracker, one clock, reset active low. */
`timescale 1ns/1ns
// ====================
// checker
module sspt_tracker_chk (
    input wire       ref_clk,      // clock
    input wire       arst_n,       // async reset
    input wire       uf_tick,      // microframe pulse
    input wire [2:0] uf_pos,       // microframe index
    input wire       dn_valid,     // work offered
    input wire       dn_start,     // work taken
    input wire       dn_abort,     // abort pulse
    input wire       cs_valid,     // search request
    input wire       cs_ready,     // search idle
    input wire       cs_rsp_valid, // answer pulse
    input wire       cs_rsp_nyet   // no match
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_pos_step;
        uf_tick |=> uf_pos == $past(uf_pos) + 3'h1;
    endproperty
    a_pos_step: assert property (p_pos_step) else $error("uf_pos did not step");
    property p_pos_hold;
        !uf_tick |=> $stable(uf_pos);
    endproperty
    a_pos_hold: assert property (p_pos_hold) else $error("uf_pos moved");
    property p_dn_tick;
        uf_tick |-> !dn_valid;
    endproperty
    a_dn_tick: assert property (p_dn_tick) else $error("work offered in tick");
    property p_dn_stand;
        dn_valid && !dn_start ##1 !uf_tick |-> dn_valid;
    endproperty
    a_dn_stand: assert property (p_dn_stand) else $error("offer withdrawn");
    property p_abort;
        dn_abort |-> $past(uf_tick) ##1 !dn_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort off tick");
    property p_cs_tick;
        uf_tick |-> !cs_ready;
    endproperty
    a_cs_tick: assert property (p_cs_tick) else $error("search taken in tick");
    property p_cs_busy;
        cs_valid && cs_ready |=> !cs_ready;
    endproperty
    a_cs_busy: assert property (p_cs_busy) else $error("second search taken");
    property p_cs_ans;
        cs_valid && cs_ready |-> ##[1:33] (cs_rsp_valid || uf_tick);
    endproperty
    a_cs_ans: assert property (p_cs_ans) else $error("search unanswered");
    cover property (cs_rsp_valid && !cs_rsp_nyet);
    cover property (cs_rsp_valid && cs_rsp_nyet);
    cover property (dn_abort);
endmodule

bind sspt_tracker sspt_tracker_chk u_sspt_tracker_chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .uf_tick(uf_tick), .uf_pos(uf_pos), .dn_valid(dn_valid), .dn_start(dn_start),
    .dn_abort(dn_abort), .cs_valid(cs_valid), .cs_ready(cs_ready),
    .cs_rsp_valid(cs_rsp_valid), .cs_rsp_nyet(cs_rsp_nyet));

// ===== tb/sspt_handler_model.sv
/* downstream handler model: runs one offered transaction at a time.
   assumes: result code is the low endpoint bits, length echoed. */
`timescale 1ns/1ns
// ====================
// handler
module sspt_handler_model (
    input  wire        ref_clk,  // clock
    input  wire        arst_n,   // async reset
    input  wire        slow,     // run past four microframes
    input  wire        dn_valid, // work offered
    input  wire [10:0] dn_ep,    // its endpoint
    input  wire [9:0]  dn_len,   // its length
    output wire        dn_start, // take it
    input  wire        dn_abort, // drop running one
    output reg         rs_valid, // result ready
    input  wire        rs_ready, // result taken
    output reg  [9:0]  rs_len,   // result bytes
    output reg  [2:0]  rs_code   // result status
);
    reg       busy;
    reg [8:0] cnt;
    // no take in the abort cycle, the abort branch would swallow the start
    assign dn_start = dn_valid && !busy && !dn_abort;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy     <= 1'b0;
            cnt      <= 9'h000;
            rs_valid <= 1'b0;
            rs_len   <= 10'h3FF;
            rs_code  <= 3'h7;
        end else if (dn_abort) begin
            busy     <= 1'b0;
            rs_valid <= 1'b0;
        end else if (rs_valid) begin
            if (rs_ready) begin
                rs_valid <= 1'b0;
                busy     <= 1'b0;
                rs_len   <= ~rs_len; // released lines must not keep the last value
                rs_code  <= ~rs_code;
            end
        end else if (busy) begin
            cnt <= cnt - 9'h001;
            if (cnt == 9'h000)
                rs_valid <= 1'b1;
        end else if (dn_start) begin
            busy    <= 1'b1;
            cnt     <= slow ? 9'h12C : 9'h003;
            rs_len  <= dn_len;
            rs_code <= dn_ep[2:0];
        end
    end
endmodule

// ===== tb/tb_sspt_tracker.sv
/* testbench for the split pipeline tracker.
   assumes: handler model and checker compiled first. */
`timescale 1ns/1ns
// ====================
// bench top
module tb_sspt_tracker;
    reg         ref_clk, arst_n, uf_tick, ss_valid, ss_intr, cs_valid, slow;
    reg  [10:0] ss_ep, cs_ep;
    reg  [9:0]  ss_len;
    wire [2:0]  uf_pos, rs_code, cs_rsp_code;
    wire [10:0] dn_ep;
    wire [9:0]  dn_len, rs_len, cs_rsp_len;
    wire        ss_ready, dn_valid, dn_start, dn_abort, dn_no_retry;
    wire        rs_valid, rs_ready, cs_ready, cs_rsp_valid, cs_rsp_nyet;
    integer     errors, total_checks, cycles, n_abort, nt;
    sspt_tracker u_sspt_tracker (.ref_clk(ref_clk), .arst_n(arst_n), .uf_tick(uf_tick),
        .uf_pos(uf_pos), .ss_valid(ss_valid), .ss_ready(ss_ready), .ss_ep(ss_ep),
        .ss_len(ss_len), .ss_intr(ss_intr), .dn_valid(dn_valid), .dn_ep(dn_ep),
        .dn_len(dn_len), .dn_start(dn_start), .dn_abort(dn_abort),
        .dn_no_retry(dn_no_retry), .rs_valid(rs_valid), .rs_ready(rs_ready),
        .rs_len(rs_len), .rs_code(rs_code), .cs_valid(cs_valid), .cs_ready(cs_ready),
        .cs_ep(cs_ep), .cs_rsp_valid(cs_rsp_valid), .cs_rsp_nyet(cs_rsp_nyet),
        .cs_rsp_code(cs_rsp_code), .cs_rsp_len(cs_rsp_len));
    sspt_handler_model u_sspt_handler_model (.ref_clk(ref_clk), .arst_n(arst_n),
        .slow(slow), .dn_valid(dn_valid), .dn_ep(dn_ep), .dn_len(dn_len),
        .dn_start(dn_start), .dn_abort(dn_abort), .rs_valid(rs_valid),
        .rs_ready(rs_ready), .rs_len(rs_len), .rs_code(rs_code));
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (dn_abort === 1'b1) n_abort <= n_abort + 1;
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            errors = errors + 1;
            close_out;
        end
    end
    // ====================
    // shared tasks
    task close_out;
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task chk(input string name, input [15:0] exp, input [15:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task tick;
        uf_tick = 1'b1;
        cyc(1);
        uf_tick = 1'b0;
        nt = nt + 1;
        chk("uf_pos", nt % 8, uf_pos);
        cyc(1);
    endtask
    task store(input [10:0] ep, input [9:0] len, input intr);
        ss_valid = 1'b1;
        ss_ep = ep;
        ss_len = len;
        ss_intr = intr;
        while (ss_ready !== 1'b1) cyc(1);
        cyc(1);
        ss_valid = 1'b0;
        cyc(1);
    endtask
    // hit expects code and length; a miss expects only the no-match flag
    task csplit(input [10:0] ep, input nyet, input [2:0] code, input [9:0] len);
        integer i;
        while (cs_ready !== 1'b1) cyc(1);
        cs_valid = 1'b1;
        cs_ep = ep;
        cyc(1);
        cs_valid = 1'b0;
        i = 0;
        while (cs_rsp_valid !== 1'b1 && i < 40) begin
            cyc(1);
            i = i + 1;
        end
        chk("cs_rsp_valid", 1, cs_rsp_valid);
        chk("cs_rsp_nyet", nyet, cs_rsp_nyet);
        if (!nyet) begin
            chk("cs_rsp_code", code, cs_rsp_code);
            chk("cs_rsp_len", len, cs_rsp_len);
        end
        cyc(1);
    endtask
    // ====================
    // scenarios
    task scn_budget;
        ss_len = 10'h2F0;
        cyc(1);
        chk("ss_ready", 0, ss_ready);
        ss_len = 10'h2EF;
        cyc(1);
        chk("ss_ready", 1, ss_ready);
    endtask
    // a tick in mid-search drops it silently; the retry is answered
    task scn_drop;
        integer i;
        while (cs_ready !== 1'b1) cyc(1);
        cs_valid = 1'b1;
        cs_ep = 11'h00A;
        cyc(1);
        cs_valid = 1'b0;
        cyc(4);
        tick;
        i = 0;
        while (cs_rsp_valid !== 1'b1 && i < 40) begin
            cyc(1);
            i = i + 1;
        end
        chk("cs_rsp_valid", 0, cs_rsp_valid);
        csplit(11'h00A, 1'b1, 3'h0, 10'h000);
    endtask
    task scn_front;
        store(11'h005, 10'h008, 1'b0);
        chk("dn_valid", 0, dn_valid);
        csplit(11'h005, 1'b1, 3'h0, 10'h000);
        tick;
        cyc(20);
        chk("dn_no_retry", 0, dn_no_retry);
        tick;
        csplit(11'h005, 1'b0, 3'h5, 10'h008);
        csplit(11'h005, 1'b0, 3'h5, 10'h008);
        tick;
        csplit(11'h005, 1'b1, 3'h0, 10'h000);
    endtask
    task scn_skip;
        store(11'h001, 10'h001, 1'b0);
        store(11'h002, 10'h002, 1'b0);
        store(11'h003, 10'h003, 1'b0);
        tick;
        cyc(30);
        tick;
        csplit(11'h003, 1'b0, 3'h3, 10'h003);
        csplit(11'h001, 1'b1, 3'h0, 10'h000);
        csplit(11'h003, 1'b0, 3'h3, 10'h003);
    endtask
    task scn_stale;
        slow = 1'b1;
        store(11'h007, 10'h004, 1'b1);
        store(11'h006, 10'h002, 1'b0);
        tick;
        cyc(5);
        chk("dn_no_retry", 1, dn_no_retry);
        tick;
        tick;
        chk("n_abort", 0, n_abort);
        tick;
        cyc(2);
        chk("n_abort", 1, n_abort);
        chk("dn_valid", 0, dn_valid);
        slow = 1'b0;
        csplit(11'h007, 1'b1, 3'h0, 10'h000);
        csplit(11'h006, 1'b1, 3'h0, 10'h000);
    endtask
    initial begin
        {ref_clk, arst_n, uf_tick, ss_valid, ss_intr, cs_valid, slow} = 7'h00;
        {ss_ep, cs_ep, ss_len} = 32'h0;
        {errors, total_checks, cycles, n_abort, nt} = 160'h0;
        cyc(16);
        arst_n = 1'b1;
        chk("uf_pos", 0, uf_pos);
        scn_budget;
        scn_front;
        scn_skip;
        scn_stale;
        scn_drop;
        close_out;
    end
endmodule
